// >>> design/rpsc_defs.svh
`ifndef RPSC_DEFS_SVH
`define RPSC_DEFS_SVH

// ------------------------------------------------------------
// Register map (low four address bits, top bit picks nibble)
// ------------------------------------------------------------
`define RPSC_NPORTS 9
`define RPSC_AUI_ADDR 4'h1
`define RPSC_TP_FIRST 4'h2
`define RPSC_TP_LAST 4'h9
`define RPSC_NIB_HI_BIT 4
`define RPSC_UNMAPPED_NIB 4'hf

// ------------------------------------------------------------
// Field positions within the byte
// ------------------------------------------------------------
`define RPSC_B_LINK 0
`define RPSC_B_COL 1
`define RPSC_B_RXSRC 2
`define RPSC_B_PORT_PARTITIONED_N 3
`define RPSC_B_SQUELCH 4
`define RPSC_B_POLARITY 5
`define RPSC_B_TEST 6
`define RPSC_B_DIS 7

// ------------------------------------------------------------
// Reset values of the writable fields
// ------------------------------------------------------------
`define RPSC_RST_DIS 1'b0
`define RPSC_RST_LINK_OFF 1'b0
`define RPSC_RST_SQUELCH 1'b0
`define RPSC_RST_TEST 1'b0

`endif

// >>> design/rpsc_pkg.sv
package rpsc_pkg;

  // Per-port status from the repeater core
  typedef struct packed {
    logic collision;
    logic rx_source;
    logic partitioned;
    logic link_pulse_seen;
    logic rx_polarity_inverted;
  } rpsc_port_stat_t;

  // Per-port controls toward the repeater core
  typedef struct packed {
    logic port_disable;
    logic reconnect;
    logic link_pulse_off;
    logic reduced_squelch_select;
    logic test_mode;
  } rpsc_port_cfg_t;

  // Result of an address decode
  typedef struct packed {
    logic hit;
    logic [3:0] idx;
  } rpsc_sel_t;

  // Register pin access phase
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RD = 3'b010,
    ST_WR = 3'b100
  } rpsc_state_t;

endpackage

// >>> design/rpsc_port_slice.sv
`timescale 1ns/1ps
`include "rpsc_defs.svh"

module rpsc_port_slice #(
  parameter bit IS_TP = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Core side
  input rpsc_pkg::rpsc_port_stat_t stat_i,
  input wire logic event_start_i,
  output rpsc_pkg::rpsc_port_cfg_t cfg_o,
  // Register side
  input wire logic wr_lo_i,
  input wire logic wr_hi_i,
  input wire logic [3:0] wr_nib_i,
  output logic [7:0] byte_o
);

  logic col_seen_r;
  logic rxsrc_seen_r;
  logic dis_r;
  logic reconnect_r;
  logic link_off_r;
  logic squelch_r;
  logic test_r;
  logic col_now;
  logic rxsrc_now;

  // A disabled port contributes no activity
  assign col_now = stat_i.collision & ~dis_r;
  assign rxsrc_now = stat_i.rx_source & ~dis_r;

  // cleared by new event, set wins
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      col_seen_r <= 1'b0;
    end else if (col_now) begin
      col_seen_r <= 1'b1;
    end else if (event_start_i) begin
      col_seen_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rxsrc_seen_r <= 1'b0;
    end else if (rxsrc_now) begin
      rxsrc_seen_r <= 1'b1;
    end else if (event_start_i) begin
      rxsrc_seen_r <= 1'b0;
    end
  end

  // one-cycle reconnect pulse on write 1
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reconnect_r <= 1'b0;
    end else begin
      reconnect_r <= wr_lo_i & wr_nib_i[`RPSC_B_PORT_PARTITIONED_N];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dis_r <= `RPSC_RST_DIS;
    end else if (wr_hi_i) begin
      dis_r <= wr_nib_i[`RPSC_B_DIS - 4];
    end
  end

  // link pulse handling on or off
  // squelch select; the attachment port keeps these at reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link_off_r <= `RPSC_RST_LINK_OFF;
      squelch_r <= `RPSC_RST_SQUELCH;
      test_r <= `RPSC_RST_TEST;
    end else begin
      if (IS_TP && wr_lo_i) begin
        link_off_r <= wr_nib_i[`RPSC_B_LINK];
      end
      if (IS_TP && wr_hi_i) begin
        squelch_r <= wr_nib_i[`RPSC_B_SQUELCH - 4];
        test_r <= wr_nib_i[`RPSC_B_TEST - 4];
      end
    end
  end

  assign cfg_o = '{port_disable: dis_r, reconnect: reconnect_r, link_pulse_off: link_off_r,
                   reduced_squelch_select: squelch_r, test_mode: test_r};

  // Read byte; active-low status bits except polarity, which reads 1 when inverted
  // on the attachment port link, polarity, reserved read 0
  always_comb begin
    byte_o = 8'h00;
    byte_o[`RPSC_B_COL] = ~(col_seen_r | col_now);
    byte_o[`RPSC_B_RXSRC] = ~(rxsrc_seen_r | rxsrc_now);
    byte_o[`RPSC_B_PORT_PARTITIONED_N] = ~stat_i.partitioned;
    byte_o[`RPSC_B_DIS] = dis_r;
    if (IS_TP) begin
      // Monitoring off means no pulses are counted as seen
      byte_o[`RPSC_B_LINK] = ~(stat_i.link_pulse_seen & ~link_off_r);
      byte_o[`RPSC_B_SQUELCH] = squelch_r;
      byte_o[`RPSC_B_POLARITY] = stat_i.rx_polarity_inverted;
      byte_o[`RPSC_B_TEST] = test_r;
    end
  end

endmodule

// >>> design/rpsc_regs.sv
`timescale 1ns/1ps
`include "rpsc_defs.svh"


module rpsc_regs #(
  parameter int NPORTS = `RPSC_NPORTS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Nibble register pins
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_rd_n_i,
  input wire logic reg_wr_n_i,
  input wire logic [3:0] reg_data_i,
  output logic [3:0] reg_data_o,
  output logic reg_data_oe_n_o,
  // Repeater core status
  input rpsc_pkg::rpsc_port_stat_t [NPORTS-1:0] port_stat_i,
  input wire logic net_event_start_i,
  // Repeater core controls
  output rpsc_pkg::rpsc_port_cfg_t [NPORTS-1:0] port_cfg_o
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [4:0] addr_s1_r;
  logic [4:0] addr_s2_r;
  logic [3:0] data_s1_r;
  logic [3:0] data_s2_r;
  logic rd_n_s1_r;
  logic rd_n_s2_r;
  logic wr_n_s1_r;
  logic wr_n_s2_r;
  rpsc_pkg::rpsc_state_t state_r;
  rpsc_pkg::rpsc_state_t state_nxt;
  logic [4:0] wr_addr_r;
  logic [3:0] wr_nib_r;
  logic commit;
  rpsc_pkg::rpsc_sel_t rd_sel;
  rpsc_pkg::rpsc_sel_t wr_sel;
  logic [7:0] port_byte [NPORTS];
  logic [7:0] rd_byte;
  logic [3:0] rd_nib;
  logic [3:0] data_r;
  logic oe_n_r;
  logic [NPORTS-1:0] wr_lo;
  logic [NPORTS-1:0] wr_hi;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  // addresses 1 to 9 map onto ports 0 to 8
  function automatic rpsc_pkg::rpsc_sel_t addr_decode(input logic [3:0] a);
    rpsc_pkg::rpsc_sel_t s;
    s.hit = (a >= `RPSC_AUI_ADDR) && (a <= `RPSC_TP_LAST);
    s.idx = a - `RPSC_AUI_ADDR;
    return s;
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Pins come from the host's own timing, so two flops each
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_s1_r <= 5'h00;
      addr_s2_r <= 5'h00;
      data_s1_r <= 4'h0;
      data_s2_r <= 4'h0;
    end else begin
      addr_s1_r <= reg_addr_i;
      addr_s2_r <= addr_s1_r;
      data_s1_r <= reg_data_i;
      data_s2_r <= data_s1_r;
    end
  end

  // Strobes idle high after reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_n_s1_r <= 1'b1;
      rd_n_s2_r <= 1'b1;
      wr_n_s1_r <= 1'b1;
      wr_n_s2_r <= 1'b1;
    end else begin
      rd_n_s1_r <= reg_rd_n_i;
      rd_n_s2_r <= rd_n_s1_r;
      wr_n_s1_r <= reg_wr_n_i;
      wr_n_s2_r <= wr_n_s1_r;
    end
  end

  // ------------------------------------------------------------
  // Access sequencer
  // ------------------------------------------------------------
  // Read wins if both strobes fall together; the write runs only if its strobe outlasts the read
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      rpsc_pkg::ST_IDLE: begin
        if (!rd_n_s2_r) begin
          state_nxt = rpsc_pkg::ST_RD;
        end else if (!wr_n_s2_r) begin
          state_nxt = rpsc_pkg::ST_WR;
        end
      end
      rpsc_pkg::ST_RD: begin
        if (rd_n_s2_r) begin
          state_nxt = rpsc_pkg::ST_IDLE;
        end
      end
      rpsc_pkg::ST_WR: begin
        if (wr_n_s2_r) begin
          state_nxt = rpsc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = rpsc_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= rpsc_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------
  // Write path
  // ------------------------------------------------------------
  // Address and data tracked while the strobe is low; the last
  // sample before release is the one committed
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_addr_r <= 5'h00;
      wr_nib_r <= 4'h0;
    end else if (state_nxt == rpsc_pkg::ST_WR) begin
      wr_addr_r <= addr_s2_r;
      wr_nib_r <= data_s2_r;
    end
  end

  // Commit on the release of the write strobe
  assign commit = (state_r == rpsc_pkg::ST_WR) && wr_n_s2_r;
  assign wr_sel = addr_decode(wr_addr_r[3:0]);

  // Per-port nibble write strobes
  // top address bit picks the upper nibble
  always_comb begin
    wr_lo = '0;
    wr_hi = '0;
    for (int p = 0; p < NPORTS; p++) begin
      if (commit && wr_sel.hit && (wr_sel.idx == 4'(p))) begin
        wr_lo[p] = ~wr_addr_r[`RPSC_NIB_HI_BIT];
        wr_hi[p] = wr_addr_r[`RPSC_NIB_HI_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // Port slices
  // ------------------------------------------------------------
  // Port 0 is the attachment port, the rest twisted pair
  for (genvar g = 0; g < NPORTS; g++) begin : g_port
    rpsc_port_slice #(
      .IS_TP(g != 0)
    ) u_slice (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .stat_i(port_stat_i[g]),
      .event_start_i(net_event_start_i),
      .cfg_o(port_cfg_o[g]),
      .wr_lo_i(wr_lo[g]),
      .wr_hi_i(wr_hi[g]),
      .wr_nib_i(wr_nib_r),
      .byte_o(port_byte[g])
    );
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  assign rd_sel = addr_decode(addr_s2_r[3:0]);

  // Unmapped addresses answer all ones, the idle status level
  always_comb begin
    rd_byte = {2{`RPSC_UNMAPPED_NIB}};
    if (rd_sel.hit) begin
      rd_byte = port_byte[rd_sel.idx];
    end
  end

  assign rd_nib = addr_s2_r[`RPSC_NIB_HI_BIT] ? rd_byte[7:4] : rd_byte[3:0];

  // Data follows the address for as long as the read lasts,
  // so live status is seen, not a snapshot
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_r <= 4'h0;
    end else if (state_nxt == rpsc_pkg::ST_RD) begin
      data_r <= rd_nib;
    end
  end

  // Drive enable, low while reading
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= (state_nxt != rpsc_pkg::ST_RD);
    end
  end

  assign reg_data_o = data_r;
  assign reg_data_oe_n_o = oe_n_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // upper nibble read
  a_upper_nibble_read: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (state_nxt == rpsc_pkg::ST_RD) && rd_sel.hit && addr_s2_r[`RPSC_NIB_HI_BIT]
    |=> (reg_data_o == $past(rd_byte[7:4])) && !reg_data_oe_n_o)
    else $error("upper nibble read wrong");

  a_lower_nibble_read: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (state_nxt == rpsc_pkg::ST_RD) && rd_sel.hit && !addr_s2_r[`RPSC_NIB_HI_BIT]
    |=> reg_data_o == $past(rd_byte[3:0]))
    else $error("lower nibble read wrong");

  a_port_write_map: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    commit && wr_addr_r[`RPSC_NIB_HI_BIT] && (wr_addr_r[3:0] == `RPSC_TP_LAST)
    |=> port_cfg_o[NPORTS-1].port_disable == $past(wr_nib_r[`RPSC_B_DIS - 4]))
    else $error("last port not written");

  a_reconnect_pulse: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    wr_lo[0] && wr_nib_r[`RPSC_B_PORT_PARTITIONED_N] |=> port_cfg_o[0].reconnect ##1 !port_cfg_o[0].reconnect)
    else $error("reconnect pulse wrong");

  a_aui_reserved: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    wr_hi[0] |=> ##1 (port_byte[0][`RPSC_B_TEST:`RPSC_B_SQUELCH] == 3'h0) && !port_cfg_o[0].test_mode)
    else $error("reserved bits changed");

  // Driver enabled only during a read
  a_drive_in_read: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !reg_data_oe_n_o |-> $past(state_nxt) == rpsc_pkg::ST_RD)
    else $error("data driven outside read");

  a_disable_quiet: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    port_cfg_o[1].port_disable && !$past(port_byte[1][`RPSC_B_COL]) == 1'b0 && net_event_start_i
    && port_cfg_o[1].port_disable |=> port_byte[1][`RPSC_B_COL] || !port_cfg_o[1].port_disable)
    else $error("disabled port reports collision");

  // link reads absent while monitoring is off
  a_link_off_read: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    wr_lo[1] && wr_nib_r[`RPSC_B_LINK] |=> port_cfg_o[1].link_pulse_off && port_byte[1][`RPSC_B_LINK])
    else $error("link monitor not off");

  a_collision_bit: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    port_stat_i[2].collision && !port_cfg_o[2].port_disable |-> !port_byte[2][`RPSC_B_COL] ##1
    !port_byte[2][`RPSC_B_COL] || port_cfg_o[2].port_disable)
    else $error("collision not held");

  a_event_clear: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    net_event_start_i && !port_stat_i[2].collision ##1 !port_stat_i[2].collision
    |-> port_byte[2][`RPSC_B_COL])
    else $error("collision not cleared by event");

endmodule

// >>> verification/rpsc_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Host processor on the nibble pins
// ----------------------------------------
module rpsc_host_model (
  // Clock
  input wire logic clk_i,
  // Pins toward the device
  output logic [4:0] addr_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [3:0] data_o,
  // Pins from the device
  input wire logic [3:0] data_i,
  input wire logic data_oe_n_i
);
  // Idle pins at time zero
  initial begin
    addr_o = 5'h00;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    data_o = 4'h0;
  end

  // Read a nibble; strobe held past the three-edge answer time
  task automatic rd(input logic [4:0] a, output logic [3:0] d, output logic oe_n);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_n_o = 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    d = data_i;
    oe_n = data_oe_n_i;
    rd_n_o = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    addr_o = ~a; // Released lines never keep the old value
  endtask

  // Write a nibble; address and data outlive the strobe by three edges
  task automatic wr(input logic [4:0] a, input logic [3:0] d);
    logic [3:0] v;
    v = d;
    if (a[4]) v[2] = 1'b0;
    @(posedge clk_i);
    #1;
    addr_o = a;
    data_o = v;
    wr_n_o = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    wr_n_o = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    data_o = ~v;
    addr_o = ~a;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
endmodule

// >>> verification/tb_rpsc_regs.sv
`timescale 1ns/1ps

module tb_rpsc_regs;
  localparam int NP = 9;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] addr;
  logic rd_n;
  logic wr_n;
  logic [3:0] din;
  logic [3:0] dout;
  logic oe_n;
  logic net_ev;
  rpsc_pkg::rpsc_port_stat_t [NP-1:0] stat;
  rpsc_pkg::rpsc_port_stat_t [NP-1:0] stat_a;
  rpsc_pkg::rpsc_port_cfg_t [NP-1:0] cfg;
  logic [NP-1:0] dis_e;
  logic [NP-1:0] lof_e;
  logic [NP-1:0] squelch_e;
  int recon_cnt [NP];
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;

  // ----------------------------------------
  // Clock, design and host
  // ----------------------------------------
  always #2.5 clk = ~clk;

  rpsc_regs #(.NPORTS(NP)) dut (
    .clk_i(clk), .reset_n_i(reset_n), .reg_addr_i(addr), .reg_rd_n_i(rd_n), .reg_wr_n_i(wr_n),
    .reg_data_i(din), .reg_data_o(dout), .reg_data_oe_n_o(oe_n), .port_stat_i(stat),
    .net_event_start_i(net_ev), .port_cfg_o(cfg)
  );

  rpsc_host_model host (
    .clk_i(clk), .addr_o(addr), .rd_n_o(rd_n), .wr_n_o(wr_n), .data_o(din),
    .data_i(dout), .data_oe_n_i(oe_n)
  );

  // Cycles of reconnect seen per port; a pulse longer than one cycle shows up here
  always @(posedge clk) begin
    for (int i = 0; i < NP; i++) begin
      if (cfg[i].reconnect === 1'b1) recon_cnt[i]++;
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc >= LIMIT) begin
      num_errors++;
      summarize();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic summarize();
    $display("TB: errors=%0d checks=%0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Reserved attachment-port bits are don't care
  function automatic logic [7:0] msk(input int p);
    return (p == 0) ? 8'h8e : 8'hff;
  endfunction

  // Status byte from the stimulus and the written settings
  function automatic logic [7:0] exp_byte(input int p);
    logic [7:0] b;
    b[0] = ~(stat[p].link_pulse_seen & ~lof_e[p]);
    b[1] = ~(~dis_e[p] & (stat_a[p].collision | stat[p].collision));
    b[2] = ~(~dis_e[p] & (stat_a[p].rx_source | stat[p].rx_source));
    b[3] = ~stat[p].partitioned;
    b[4] = squelch_e[p];
    b[5] = stat[p].rx_polarity_inverted;
    b[6] = 1'b0;
    b[7] = dis_e[p];
    return b;
  endfunction

  task automatic rd_byte(input int p, output logic [7:0] b);
    logic [3:0] lo;
    logic [3:0] hi;
    logic o_lo;
    logic o_hi;
    host.rd({1'b0, 4'(p + 1)}, lo, o_lo);
    host.rd({1'b1, 4'(p + 1)}, hi, o_hi);
    b = {hi, lo};
    chk({6'h00, o_lo, o_hi}, 8'h00);
  endtask

  task automatic chk_cfg();
    logic [7:0] g;
    logic [7:0] e;
    for (int i = 0; i < NP; i++) begin
      g = {4'h0, cfg[i].port_disable, cfg[i].link_pulse_off, cfg[i].reduced_squelch_select, cfg[i].test_mode};
      e = {4'h0, dis_e[i], lof_e[i], squelch_e[i], 1'b0};
      chk(g, e);
    end
  endtask

  task automatic new_event();
    stat = '0;
    @(posedge clk);
    #1 net_ev = 1'b1;
    @(posedge clk);
    #1 net_ev = 1'b0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] b;
    logic [3:0] n;
    logic o;
    logic [3:0] up;
    logic [3:0] lo;
    int p;
    int n0;
    logic [4:0] bad [4];
    bad = '{5'h00, 5'h10, 5'h0a, 5'h1f};
    stat = '0;
    stat_a = '0;
    net_ev = 1'b0;
    dis_e = '0;
    lof_e = '0;
    squelch_e = '0;
    void'($urandom(36169));
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
    // Unmapped places read all ones
    foreach (bad[i]) begin
      host.rd(bad[i], n, o);
      chk({4'h0, n}, 8'h0f);
    end
    chk_cfg();
    for (int i = 0; i < NP; i++) begin
      rd_byte(i, b);
      chk(b & msk(i), exp_byte(i) & msk(i));
    end
    // Writes to unmapped places change nothing
    host.wr(5'h1a, 4'hf);
    host.wr(5'h0a, 4'hf);
    chk_cfg();
    // Random settings and status; first round all ones, second round all zeros
    for (int it = 0; it < 72; it++) begin
      p = it % NP;
      up = (it < 9) ? 4'hf : (it < 18) ? 4'h0 : 4'($urandom);
      lo = (it < 9) ? 4'hf : (it < 18) ? 4'h0 : 4'($urandom);
      host.wr({1'b1, 4'(p + 1)}, up);
      dis_e[p] = up[3];
      if (p != 0) squelch_e[p] = up[0];
      n0 = recon_cnt[p];
      host.wr({1'b0, 4'(p + 1)}, lo);
      if (p != 0) lof_e[p] = lo[0];
      chk(8'(recon_cnt[p] - n0), {7'h00, lo[3]});
      chk_cfg();
      new_event();
      for (int i = 0; i < NP; i++) stat_a[i] = 5'($urandom);
      stat = stat_a;
      repeat (2) @(posedge clk);
      #1;
      for (int i = 0; i < NP; i++) stat[i] = 5'($urandom);
      repeat (2) @(posedge clk);
      #1;
      rd_byte(p, b);
      chk(b & msk(p), exp_byte(p) & msk(p));
      // A new event clears the sticky indications
      new_event();
      stat_a = '0;
      host.rd({1'b0, 4'(p + 1)}, n, o);
      chk({4'h0, n & 4'h6}, 8'h06);
    end
    summarize();
  end
endmodule
